// ---- logic/sbgt_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the general timer.
// Assumes: Included by the timer module and the testbench.
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
`ifndef SBGT_CONSTS_SVH
`define SBGT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SBGT_OFF_CTRL 8'h00
`define SBGT_OFF_PERIOD 8'h04
`define SBGT_OFF_COUNT 8'h08
`define SBGT_OFF_STATUS 8'h0C
`define SBGT_OFF_IRQCFG 8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SBGT_BIT_RUN 15
`define SBGT_BIT_IDLESTOP 13
`define SBGT_BIT_GATE 6
`define SBGT_BIT_PS_HI 5
`define SBGT_BIT_PS_LO 4
`define SBGT_BIT_SYNC 2
`define SBGT_BIT_CLKSRC 1
`define SBGT_BIT_FLAG 0
`define SBGT_BIT_IE 0
`define SBGT_BIT_PRI_HI 3
`define SBGT_BIT_PRI_LO 1

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define SBGT_RST_CTRL 16'h0000
`define SBGT_RST_PERIOD 16'hFFFF
`define SBGT_CTRL_MASK 32'h0000A076
`define SBGT_PS_LIM_1 8'h00
`define SBGT_PS_LIM_8 8'h07
`define SBGT_PS_LIM_64 8'h3F
`define SBGT_PS_LIM_256 8'hFF
`define SBGT_RESP_OKAY 2'b00
`define SBGT_RESP_SLVERR 2'b10

`endif

// ---- logic/sbgt_pkg.sv ----
// Purpose: Types shared by the general timer.
// Assumes: Constants come from sbgt_consts.svh.
// Notes:   Holds only types.
package sbgt_pkg;

  // --------------------------------------------------------------------------
  // Prescale ratio codes and the control word
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBGT_PS_1 = 2'b00,
    SBGT_PS_8 = 2'b01,
    SBGT_PS_64 = 2'b10,
    SBGT_PS_256 = 2'b11
  } sbgt_pscale_t;

  typedef struct packed {
    logic runControl;
    logic idleStopSelect;
    logic gateAccumulateEnable;
    sbgt_pscale_t prescaleSelect;
    logic extClockSyncSelect;
    logic clockSourceSelect;
  } sbgt_ctrl_t;

endpackage : sbgt_pkg

// ---- logic/sbgt_timer.sv ----
// Purpose: 16-bit general timer/counter with period match, gate and prescaler, AXI4-Lite slave.
// Assumes: clk_sys is the oscillator; all pins are synchronous to clk_sys.
// Notes:   The internal count clock is clk_sys divided by two.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`include "sbgt_consts.svh"

module sbgt_timer
  import sbgt_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extClockPin,
  input wire logic gatePin,
  input wire logic cpuIdle,
  input wire logic cpuSleep,
  output logic timerIrq,
  output logic [2:0] timerIrqPriority,
  output logic rtcTick
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  if (CNT_W < 8 || CNT_W > 16)
  begin : g_bad_width
    $error("CNT_W must lie between 8 and 16.");
  end

  // Prescaler terminal value for a ratio code.
  function automatic logic [7:0] psLimit(input sbgt_pscale_t ps);
    case (ps)
      SBGT_PS_1: psLimit = `SBGT_PS_LIM_1;
      SBGT_PS_8: psLimit = `SBGT_PS_LIM_8;
      SBGT_PS_64: psLimit = `SBGT_PS_LIM_64;
      SBGT_PS_256: psLimit = `SBGT_PS_LIM_256;
      default: psLimit = `SBGT_PS_LIM_1;
    endcase
  endfunction : psLimit

  // Merges the low two byte lanes of a write into a 16-bit register value.
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    laneMerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : laneMerge

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  sbgt_ctrl_t ctrl_r;
  logic [CNT_W-1:0] period_r;
  logic [CNT_W-1:0] count_r;
  logic [7:0] psCnt_r;
  logic flag_r;
  logic ie_r;
  logic [2:0] pri_r;
  logic intPhase_r;
  logic extSync1_r;
  logic extSync2_r;
  logic extSync3_r;
  logic extRaw_r;
  logic gateSync1_r;
  logic gateSync2_r;
  logic gateSync3_r;
  logic awHave_r;
  logic wHave_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire wrDo = awHave_r && wHave_r && !s_axi_bvalid;
  wire lowLanes = wStrb_r[0] || wStrb_r[1];
  wire wrCtrl = wrDo && awAddr_r == `SBGT_OFF_CTRL && lowLanes;
  wire wrPeriod = wrDo && awAddr_r == `SBGT_OFF_PERIOD && lowLanes;
  wire wrCount = wrDo && awAddr_r == `SBGT_OFF_COUNT && lowLanes;
  wire wrStatus = wrDo && awAddr_r == `SBGT_OFF_STATUS && wStrb_r[0];
  wire wrIrq = wrDo && awAddr_r == `SBGT_OFF_IRQCFG && wStrb_r[0];
  wire wrMapped = awAddr_r == `SBGT_OFF_CTRL || awAddr_r == `SBGT_OFF_PERIOD ||
    awAddr_r == `SBGT_OFF_COUNT || awAddr_r == `SBGT_OFF_STATUS ||
    awAddr_r == `SBGT_OFF_IRQCFG;
  wire [15:0] periodMerged = laneMerge(16'(period_r), wData_r, wStrb_r); // Unstrobed lanes kept.
  wire [15:0] countMerged = laneMerge(16'(count_r), wData_r, wStrb_r);
  wire [15:0] ctrlLowOld = {ctrl_r.runControl, 1'b0, ctrl_r.idleStopSelect, 6'h00,
    ctrl_r.gateAccumulateEnable, ctrl_r.prescaleSelect, 1'b0, ctrl_r.extClockSyncSelect,
    ctrl_r.clockSourceSelect, 1'b0};
  wire [15:0] ctrlMerged = laneMerge(ctrlLowOld, wData_r, wStrb_r);

  // Read multiplexer; reserved control bits read as zero.
  wire [31:0] ctrlRead = {16'h0000, ctrlLowOld};
  wire rdMapped = s_axi_araddr == `SBGT_OFF_CTRL || s_axi_araddr == `SBGT_OFF_PERIOD ||
    s_axi_araddr == `SBGT_OFF_COUNT || s_axi_araddr == `SBGT_OFF_STATUS ||
    s_axi_araddr == `SBGT_OFF_IRQCFG;
  wire [31:0] rdMux =
    (s_axi_araddr == `SBGT_OFF_CTRL) ? ctrlRead :
    (s_axi_araddr == `SBGT_OFF_PERIOD) ? 32'(period_r) :
    (s_axi_araddr == `SBGT_OFF_COUNT) ? 32'(count_r) :
    (s_axi_araddr == `SBGT_OFF_STATUS) ? {31'h00000000, flag_r} :
    (s_axi_araddr == `SBGT_OFF_IRQCFG) ? {28'h0000000, pri_r, ie_r} : 32'h00000000;

  // --------------------------------------------------------------------------
  // Count clock selection
  // --------------------------------------------------------------------------
  // Internal clock ticks every second oscillator cycle.
  wire intTick = intPhase_r;
  // Synchronised path reads only the second and third flops.
  wire extSyncEdge = extSync2_r && !extSync3_r;
  // Unsynchronised path samples the pin directly for its rising edge.
  wire extRawEdge = extClockPin && !extRaw_r;
  wire extEdge = ctrl_r.extClockSyncSelect ? extSyncEdge : extRawEdge;
  wire srcTick = ctrl_r.clockSourceSelect ? extEdge : intTick;
  wire asyncMode = ctrl_r.clockSourceSelect && !ctrl_r.extClockSyncSelect;
  // Idle halts only with idle-stop set; sleep stops all but the unsynchronised counter.
  wire halted = !ctrl_r.runControl || (cpuIdle && ctrl_r.idleStopSelect) ||
    (cpuSleep && !asyncMode);
  // Gating applies to the internal clock only.
  wire gateOpen = ctrl_r.clockSourceSelect || !ctrl_r.gateAccumulateEnable ||
    gateSync2_r;
  wire gateFall = !gateSync2_r && gateSync3_r;
  wire gateFallEv = gateFall && ctrl_r.gateAccumulateEnable && !ctrl_r.clockSourceSelect &&
    ctrl_r.runControl;
  wire [7:0] psLim = psLimit(ctrl_r.prescaleSelect);
  wire psStep = srcTick && !halted && gateOpen;
  wire cntTick = psStep && psCnt_r >= psLim;
  wire match = cntTick && count_r == period_r;
  wire flagClr = wrStatus && wData_r[`SBGT_BIT_FLAG];
  wire flag_nxt = match || gateFallEv || (flag_r && !flagClr);
  wire [CNT_W-1:0] count_nxt = wrCount ? countMerged[CNT_W-1:0] :
    match ? '0 : cntTick ? count_r + 1'b1 : count_r;

  // --------------------------------------------------------------------------
  // Bus handshake registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBGT_RESP_OKAY;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end
    else
    begin
      if (awTake)
      begin
        awHave_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (wTake)
      begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrDo)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `SBGT_RESP_OKAY : `SBGT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SBGT_RESP_OKAY;
    end
    else if (arTake)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdMapped ? `SBGT_RESP_OKAY : `SBGT_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= sbgt_ctrl_t'(7'h00);
      period_r <= CNT_W'(`SBGT_RST_PERIOD);
      ie_r <= 1'b0;
      pri_r <= 3'h0;
    end
    else
    begin
      if (wrCtrl)
      begin
        ctrl_r.runControl <= ctrlMerged[`SBGT_BIT_RUN];
        ctrl_r.idleStopSelect <= ctrlMerged[`SBGT_BIT_IDLESTOP];
        ctrl_r.gateAccumulateEnable <= ctrlMerged[`SBGT_BIT_GATE];
        ctrl_r.prescaleSelect <= sbgt_pscale_t'(ctrlMerged[`SBGT_BIT_PS_HI:`SBGT_BIT_PS_LO]);
        ctrl_r.extClockSyncSelect <= ctrlMerged[`SBGT_BIT_SYNC];
        ctrl_r.clockSourceSelect <= ctrlMerged[`SBGT_BIT_CLKSRC];
      end
      if (wrPeriod)
        period_r <= periodMerged[CNT_W-1:0];
      if (wrIrq)
      begin
        ie_r <= wData_r[`SBGT_BIT_IE];
        pri_r <= wData_r[`SBGT_BIT_PRI_HI:`SBGT_BIT_PRI_LO];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Counting core
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      intPhase_r <= 1'b0;
      extSync1_r <= 1'b0;
      extSync2_r <= 1'b0;
      extSync3_r <= 1'b0;
      extRaw_r <= 1'b0;
      gateSync1_r <= 1'b0;
      gateSync2_r <= 1'b0;
      gateSync3_r <= 1'b0;
      psCnt_r <= 8'h00;
      count_r <= '0;
      flag_r <= 1'b0;
    end
    else
    begin
      intPhase_r <= !intPhase_r;
      extSync1_r <= extClockPin;
      extSync2_r <= extSync1_r;
      extSync3_r <= extSync2_r;
      extRaw_r <= extClockPin;
      gateSync1_r <= gatePin;
      gateSync2_r <= gateSync1_r;
      gateSync3_r <= gateSync2_r;
      // Prescaler clears while stopped so a restart begins a full division.
      psCnt_r <= !ctrl_r.runControl || cntTick ? 8'h00 : psStep ? psCnt_r + 8'h01 : psCnt_r;
      count_r <= count_nxt;
      flag_r <= flag_nxt;
    end
  end

  // Interrupt request, priority and time-base tick leave from flops.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timerIrq <= 1'b0;
      timerIrqPriority <= 3'h0;
      rtcTick <= 1'b0;
    end
    else
    begin
      timerIrq <= flag_r && ie_r;
      timerIrqPriority <= pri_r;
      rtcTick <= match;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  match_wrap_a: assert property (match && !wrCount |=> count_r == '0 && flag_r)
    else $error("Counter did not wrap to zero with flag on match.");
  count_step_a: assert property (cntTick && !match && !wrCount |=>
    count_r == $past(count_r) + 1'b1)
    else $error("Counter did not advance on a count tick.");
  stop_hold_a: assert property (!ctrl_r.runControl && !wrCount |=> $stable(count_r))
    else $error("Stopped counter changed.");
  idle_halt_a: assert property (cpuIdle && ctrl_r.idleStopSelect && !wrCount |=>
    $stable(count_r))
    else $error("Counter moved in idle with idle stop set.");
  gate_fall_a: assert property (gateFallEv && !wrStatus |=> flag_r)
    else $error("Gate falling edge did not set the flag.");
  gate_block_a: assert property (!ctrl_r.clockSourceSelect && ctrl_r.gateAccumulateEnable &&
    !gateSync2_r |-> !cntTick)
    else $error("Counter ticked with gate closed.");
  ps_div_a: assert property (cntTick |-> psCnt_r == psLimit(ctrl_r.prescaleSelect))
    else $error("Count tick came off the prescale ratio.");
  sync_edge_a: assert property (ctrl_r.clockSourceSelect && ctrl_r.extClockSyncSelect &&
    !halted && ctrl_r.prescaleSelect == SBGT_PS_1 && $rose(extSync2_r) |-> cntTick)
    else $error("Synchronised external edge was not counted.");
  int_rate_a: assert property (!ctrl_r.clockSourceSelect && cntTick |=> !cntTick)
    else $error("Internal clock counted faster than half rate.");
  irq_gate_a: assert property (##1 timerIrq == $past(flag_r && ie_r))
    else $error("Interrupt output disagrees with flag and enable.");
  rtc_tick_a: assert property (match |=> rtcTick)
    else $error("Time-base tick missing after match.");
  ctrl_zero_a: assert property (arTake && s_axi_araddr == `SBGT_OFF_CTRL |=>
    (s_axi_rdata & ~`SBGT_CTRL_MASK) == 32'h00000000)
    else $error("Unimplemented control bits read as one.");

  match_c: cover property (match);
  gate_fall_c: cover property (gateFallEv);
  async_c: cover property (asyncMode && cntTick);
  ps256_c: cover property (cntTick && ctrl_r.prescaleSelect == SBGT_PS_256);

endmodule : sbgt_timer

// ---- bench/sbgt_pin_src.sv ----
// Purpose: Far-side source of the external count clock and of the gate level.
// Assumes: Both pins change just after a rising edge of clk_sys.
// Notes:   The count clock rests low outside a burst; halfPer sets prompt or slow edges.
module sbgt_pin_src (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] nPulse,
  input wire logic [3:0] halfPer,
  input wire logic gateLevel,
  output logic extClockPin,
  output logic gatePin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] pulsesLeft_r;
  logic [3:0] phase_r;

  // ----------------------------------------------------------------------
  // Burst generator
  // ----------------------------------------------------------------------
  // Emits nPulse rising edges, each level lasting halfPer+1 cycles.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      extClockPin <= 1'b0;
      gatePin <= 1'b0;
      busy <= 1'b0;
      pulsesLeft_r <= 8'h00;
      phase_r <= 4'h0;
    end
    else
    begin
      gatePin <= gateLevel;
      if (go && !busy)
      begin
        pulsesLeft_r <= nPulse;
        phase_r <= 4'h0;
        busy <= (nPulse != 8'h00);
      end
      else if (busy && phase_r != halfPer)
        phase_r <= phase_r + 4'h1;
      else if (busy)
      begin
        phase_r <= 4'h0;
        extClockPin <= ~extClockPin;
        pulsesLeft_r <= pulsesLeft_r - {7'h00, extClockPin};
        busy <= !(extClockPin && pulsesLeft_r == 8'h01);
      end
    end
  end
endmodule : sbgt_pin_src

// ---- bench/sbgt_tb.sv ----
// Purpose: Self-checking bench of the general timer.
// Assumes: The pin source model drives the count clock and the gate.
// Notes:   Registers are reached over AXI4-Lite; stopped-count cases run from a table.
`include "sbgt_consts.svh"
module testbench import sbgt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [2:0] pins;
    logic [7:0] np;
    logic [3:0] hp;
    logic [15:0] exp;
  } sbgt_row_t;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awAddr = 8'h00;
  logic [7:0] arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'hF;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic cpuIdle = 1'b0, cpuSleep = 1'b0, go = 1'b0, gateLevel = 1'b0;
  logic [7:0] nPulse = 8'h00;
  logic [3:0] halfPer = 4'h0;
  logic awReady, wReady, bValid, arReady, rValid, extClockPin, gatePin, busy, timerIrq, rtcTick;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [2:0] irqPri;
  int n_errors = 0;
  int n_tests = 0;
  int gapExp [4] = '{8, 64, 512, 2048};

  // Counts after a burst with the timer then stopped: {sleep, idle, gate} in pins.
  sbgt_row_t rows [10] = '{
    '{16'h8006, 3'h0, 8'h05, 4'h0, 16'h0005},
    '{16'h8002, 3'h0, 8'h07, 4'h2, 16'h0007},
    '{16'h8046, 3'h0, 8'h04, 4'h1, 16'h0004},
    '{16'h8006, 3'h4, 8'h03, 4'h1, 16'h0000},
    '{16'h8002, 3'h4, 8'h03, 4'h1, 16'h0003},
    '{16'h8016, 3'h0, 8'h10, 4'h0, 16'h0002},
    '{16'h0006, 3'h0, 8'h05, 4'h0, 16'h0000},
    '{16'h8006, 3'h2, 8'h05, 4'h1, 16'h0005},
    '{16'hA006, 3'h2, 8'h05, 4'h1, 16'h0000},
    '{16'h8040, 3'h0, 8'h00, 4'h0, 16'h0000}
  };

  // ----------------------------------------------------------------------
  // Design and far-side model
  // ----------------------------------------------------------------------
  sbgt_timer #(.CNT_W(16)) u_dut (
    .clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .extClockPin(extClockPin), .gatePin(gatePin), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
    .timerIrq(timerIrq), .timerIrqPriority(irqPri), .rtcTick(rtcTick)
  );

  sbgt_pin_src u_src (
    .clk_sys(clk_sys), .rst(rst), .go(go), .nPulse(nPulse), .halfPer(halfPer),
    .gateLevel(gateLevel), .extClockPin(extClockPin), .gatePin(gatePin), .busy(busy)
  );

  // Free-running 250 MHz clock.
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic give_up();
    n_errors++;
    end_sim();
  endtask : give_up

  task automatic chk_val(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : chk_val

  // Offers address and data together and holds each until taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int k;
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (k = 0; k < 64; k++)
    begin
      @(posedge clk_sys);
      if (awReady)
        awValid <= 1'b0;
      if (wReady)
        wValid <= 1'b0;
      if (bValid)
        break;
    end
    if (k == 64)
      give_up();
    r = bResp;
    bReady <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (k = 0; k < 64; k++)
    begin
      @(posedge clk_sys);
      if (arReady)
        arValid <= 1'b0;
      if (rValid)
        break;
    end
    if (k == 64)
      give_up();
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hF, r);
    chk_val("write response", {30'h0, `SBGT_RESP_OKAY}, {30'h0, r});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk_val($sformatf("register %h", a), e, d);
  endtask : rd_chk

  // Cycles between two consecutive period-match ticks.
  task automatic tick_gap(output int n);
    int k;
    for (k = 0; k < 5000 && rtcTick !== 1'b1; k++)
      @(posedge clk_sys);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (rtcTick !== 1'b1 && n < 5000);
    if (k == 5000 || n == 5000)
      give_up();
  endtask : tick_gap

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    int k;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Table: burst of external edges or a short internal run, then the stopped count.
    foreach (rows[i])
    begin
      wr(`SBGT_OFF_CTRL, 32'h0);
      wr(`SBGT_OFF_COUNT, 32'h0);
      {cpuSleep, cpuIdle, gateLevel} <= rows[i].pins;
      nPulse <= rows[i].np;
      halfPer <= rows[i].hp;
      wr(`SBGT_OFF_CTRL, {16'h0, rows[i].ctrl});
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      for (k = 0; k < 3000 && (k < 2 || busy !== 1'b0); k++)
        @(posedge clk_sys);
      if (k == 3000)
        give_up();
      repeat (6) @(posedge clk_sys);
      wr(`SBGT_OFF_CTRL, 32'h0);
      rd_chk(`SBGT_OFF_COUNT, {16'h0, rows[i].exp});
    end
    {cpuSleep, cpuIdle, gateLevel} <= 3'h0;
    // Second reset in mid-run, then every reset value.
    wr(`SBGT_OFF_CTRL, 32'h8000);
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a < 5; a++)
      rd_chk(8'(a * 4), (a == 1) ? 32'h0000FFFF : 32'h0);
    wr(`SBGT_OFF_CTRL, 32'hFFFFFFFF);
    rd_chk(`SBGT_OFF_CTRL, `SBGT_CTRL_MASK);
    wr(`SBGT_OFF_CTRL, 32'h0);
    // Byte strobes and an unmapped offset.
    axi_write(`SBGT_OFF_PERIOD, 32'h1234, 4'h0, r);
    rd_chk(`SBGT_OFF_PERIOD, 32'h0000FFFF);
    axi_write(`SBGT_OFF_PERIOD, 32'h1234, 4'h1, r);
    rd_chk(`SBGT_OFF_PERIOD, 32'h0000FF34);
    axi_write(8'h14, 32'h1, 4'hF, r);
    chk_val("unmapped write", {30'h0, `SBGT_RESP_SLVERR}, {30'h0, r});
    axi_read(8'h14, d, r);
    chk_val("unmapped read", {30'h0, `SBGT_RESP_SLVERR}, {30'h0, r});
    chk_val("unmapped data", 32'h0, d);
    // Internal clock: match interval for every prescale ratio.
    wr(`SBGT_OFF_PERIOD, 32'h3);
    wr(`SBGT_OFF_IRQCFG, 32'hB);
    chk_val("irq priority", 32'h5, {29'h0, irqPri});
    for (int p = 0; p < 4; p++)
    begin
      wr(`SBGT_OFF_CTRL, 32'h0);
      wr(`SBGT_OFF_COUNT, 32'h0);
      wr(`SBGT_OFF_CTRL, 32'h8000 | (p << 4));
      tick_gap(n);
      chk_val("tick gap", 32'(gapExp[p]), 32'(n));
    end
    chk_val("irq enabled", 32'h1, {31'h0, timerIrq});
    wr(`SBGT_OFF_CTRL, 32'h0);
    rd_chk(`SBGT_OFF_STATUS, 32'h1);
    wr(`SBGT_OFF_STATUS, 32'h1);
    rd_chk(`SBGT_OFF_STATUS, 32'h0);
    chk_val("irq cleared", 32'h0, {31'h0, timerIrq});
    // Flag sets with the interrupt disabled, but no request leaves.
    wr(`SBGT_OFF_IRQCFG, 32'h0);
    wr(`SBGT_OFF_CTRL, 32'h8000);
    tick_gap(n);
    chk_val("irq masked", 32'h0, {31'h0, timerIrq});
    wr(`SBGT_OFF_CTRL, 32'h0);
    rd_chk(`SBGT_OFF_STATUS, 32'h1);
    wr(`SBGT_OFF_STATUS, 32'h1);
    // Gated accumulation: falling gate edge raises the flag.
    wr(`SBGT_OFF_PERIOD, 32'hFFFF);
    gateLevel <= 1'b1;
    wr(`SBGT_OFF_CTRL, 32'h8040);
    repeat (10) @(posedge clk_sys);
    gateLevel <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd_chk(`SBGT_OFF_STATUS, 32'h1);
    end_sim();
  end
endmodule : testbench
